//--- shared/flash_protection_gate_regs.vh
// constants for the flash protection gate
`ifndef FLASH_PROTECTION_GATE_REGS_VH
`define FLASH_PROTECTION_GATE_REGS_VH
`define FPG_ADDR_W     16
`define FPG_DATA_W     8
`define FPG_PW_W       16
`define FPG_PW_MSB     15
`define FPG_REG_PF     2'h0
`define FPG_REG_DF     2'h1
`define FPG_REG_ROM    2'h2
`define FPG_REG_OTHER  2'h3
`define FPG_PF_BASE    16'h0000
`define FPG_PF_TOP     16'h2fff
`define FPG_DF_BASE    16'h3000
`define FPG_DF_TOP     16'h3fff
`define FPG_ROM_BASE   16'hc000
`define FPG_ROM_TOP    16'hdfff
`define FPG_ZERO_BYTE  8'h00
`define FPG_ST_IDLE    2'h0
`define FPG_ST_WIPE    2'h1
`define FPG_ST_CLRPW   2'h2
`define FPG_ST_DONE    2'h3
`endif

//--- verilog/password_store.v
// password holding register with program and erase ports
`default_nettype none
`include "flash_protection_gate_regs.vh"
module password_store (
  input  wire                      clk_sys,
  input  wire                      rst_b,
  input  wire                      pw_prog,
  input  wire                      pw_erase,
  input  wire [`FPG_PW_W-1:0]      pw_wdata,
  output reg  [`FPG_PW_W-1:0]      pw_q,
  output reg                       pw_valid_q
);
  // erase takes priority so a wipe can never be undone by a late program
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pw_q       <= {`FPG_PW_W{1'b0}};
      pw_valid_q <= 1'b0;
    end else if (pw_erase) begin
      pw_q       <= {`FPG_PW_W{1'b0}};
      pw_valid_q <= 1'b0;
    end else if (pw_prog && !pw_valid_q) begin
      pw_q       <= pw_wdata;
      pw_valid_q <= 1'b1;
    end
  end
endmodule // password_store
`default_nettype wire

//--- verilog/flash_protection_gate.v
// flash read-out and program/erase protection gate
// Overview of operation
// - mode 0 protects program flash, and data flash erase needs the unlock bit
// - mode 1 protects program and data flash
// - program flash reads only from permitted code
// - program flash writes refused while protected
// - data flash reads restricted in mode 1
// - data flash write/erase per mode and unlock
// - mask ROM always read protected
// - match wipes protected flash then password
// - protection persists until next reset
`default_nettype none
`include "flash_protection_gate_regs.vh"
module flash_protection_gate (
  input  wire                      clk_sys,
  input  wire                      rst_b,
  // core access request
  input  wire                      req_valid,
  input  wire                      req_rd,
  input  wire                      req_prog,
  input  wire                      req_erase,
  input  wire [`FPG_ADDR_W-1:0]    req_addr,
  input  wire [`FPG_ADDR_W-1:0]    req_pc,
  input  wire [`FPG_DATA_W-1:0]    req_wdata,
  output wire                      req_ready,
  output reg                       resp_valid_q,
  output reg                       resp_refused_q,
  output reg  [`FPG_DATA_W-1:0]    resp_rdata_q,
  // data flash erase unlock bit from the miscellaneous control register
  input  wire                      data_flash_erase_unlock,
  output reg                       unlock_clear_q,
  // bootstrap loader mode 6 password port
  input  wire                      bsl_pw_prog,
  input  wire                      bsl_pw_check,
  input  wire [`FPG_PW_W-1:0]      bsl_pw_data,
  output reg                       bsl_pw_match_q,
  output reg                       bsl_pw_done_q,
  // flash array side
  output reg                       fl_rd,
  output reg                       fl_prog,
  output reg                       fl_erase,
  output reg                       fl_wipe,
  output reg  [`FPG_ADDR_W-1:0]    fl_addr,
  output reg  [`FPG_DATA_W-1:0]    fl_wdata,
  input  wire [`FPG_DATA_W-1:0]    fl_rdata,
  input  wire                      fl_wipe_done,
  output wire                      protect_active,
  output wire                      protect_mode
);
  // address decode reused for the target and for the fetching pc
  function [1:0] region;
    input [`FPG_ADDR_W-1:0] a;
    begin
      if (a >= `FPG_PF_BASE && a <= `FPG_PF_TOP)
        region = `FPG_REG_PF;
      else if (a >= `FPG_DF_BASE && a <= `FPG_DF_TOP)
        region = `FPG_REG_DF;
      else if (a >= `FPG_ROM_BASE && a <= `FPG_ROM_TOP)
        region = `FPG_REG_ROM;
      else
        region = `FPG_REG_OTHER;
    end
  endfunction

  wire [`FPG_PW_W-1:0] pw_q;
  wire                 pw_valid_q;
  reg                  pw_erase;
  reg  [1:0]           state_q;
  reg  [1:0]           state_d;
  reg                  armed_q;   // protection latched, dropped only by reset
  reg                  mode_q;

  password_store u_pw (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .pw_prog    (bsl_pw_prog),
    .pw_erase   (pw_erase),
    .pw_wdata   (bsl_pw_data),
    .pw_q       (pw_q),
    .pw_valid_q (pw_valid_q)
  );

  // armed state follows the stored password but never drops before reset
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      mode_q  <= 1'b0;
    end else if (pw_valid_q && !armed_q) begin
      // mode frozen once armed: a re-stored password cannot relax it
      armed_q <= 1'b1;
      mode_q  <= pw_q[`FPG_PW_MSB];
    end
  end
  // note: after reset the erased store leaves armed_q low

  assign protect_active = armed_q;
  assign protect_mode   = mode_q;
  assign req_ready      = (state_q == `FPG_ST_IDLE);

  // permission decode for the current request
  wire [1:0] tgt = region(req_addr);
  wire [1:0] src = region(req_pc);
  wire src_flash = (src == `FPG_REG_PF) || (src == `FPG_REG_DF);
  reg  allow;
  always @* begin
    allow = 1'b1;
    if (req_rd) begin
      if (tgt == `FPG_REG_ROM)
        allow = 1'b0;
      else if (armed_q && tgt == `FPG_REG_PF)
        allow = mode_q ? src_flash : (src == `FPG_REG_PF);
      else if (armed_q && mode_q && tgt == `FPG_REG_DF)
        allow = src_flash;
    end else begin
      if (armed_q && tgt == `FPG_REG_PF)
        allow = 1'b0;
      else if (armed_q && tgt == `FPG_REG_DF) begin
        if (mode_q)
          allow = 1'b0;
        else if (req_erase)
          allow = data_flash_erase_unlock;
      end
    end
  end

  wire take = req_valid && req_ready && (req_rd || req_prog || req_erase);
  wire pw_hit = bsl_pw_check && pw_valid_q && (bsl_pw_data == pw_q);

  // unprotect sequence: wipe protected flash, then drop the password
  always @* begin
    state_d  = state_q;
    pw_erase = 1'b0;
    case (state_q)
      `FPG_ST_IDLE: if (pw_hit) state_d = `FPG_ST_WIPE;
      `FPG_ST_WIPE: if (fl_wipe_done) state_d = `FPG_ST_CLRPW;
      `FPG_ST_CLRPW: begin
        pw_erase = 1'b1;
        state_d  = `FPG_ST_DONE;
      end
      `FPG_ST_DONE: state_d = `FPG_ST_IDLE;
      default: state_d = `FPG_ST_IDLE;
    endcase
  end

  // registered flash strobes; refused requests never reach the array
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q        <= `FPG_ST_IDLE;
      fl_rd          <= 1'b0;
      fl_prog        <= 1'b0;
      fl_erase       <= 1'b0;
      fl_wipe        <= 1'b0;
      fl_addr        <= {`FPG_ADDR_W{1'b0}};
      fl_wdata       <= `FPG_ZERO_BYTE;
      unlock_clear_q <= 1'b0;
      bsl_pw_match_q <= 1'b0;
      bsl_pw_done_q  <= 1'b0;
    end else begin
      state_q        <= state_d;
      fl_rd          <= take && req_rd && allow;
      fl_prog        <= take && !req_rd && req_prog && allow;
      fl_erase       <= take && !req_rd && req_erase && allow;
      // wipe level held for the whole wipe phase
      fl_wipe        <= (state_d == `FPG_ST_WIPE);
      // unlock is one-shot: each erase needs a fresh set
      unlock_clear_q <= take && req_erase && !req_rd && (tgt == `FPG_REG_DF);
      bsl_pw_match_q <= bsl_pw_check ? pw_hit : 1'b0;
      bsl_pw_done_q  <= (state_q == `FPG_ST_CLRPW);
      if (take) begin
        fl_addr  <= req_addr;
        fl_wdata <= req_wdata;
      end
    end
  end

  // response one cycle after the array strobe, refused reads return zero
  reg rd_pend_q;
  reg ref_pend_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_pend_q      <= 1'b0;
      ref_pend_q     <= 1'b0;
      resp_valid_q   <= 1'b0;
      resp_refused_q <= 1'b0;
      resp_rdata_q   <= `FPG_ZERO_BYTE;
    end else begin
      rd_pend_q      <= take && req_rd && allow;
      ref_pend_q     <= take && !allow;
      resp_valid_q   <= rd_pend_q || ref_pend_q || fl_prog || fl_erase;
      resp_refused_q <= ref_pend_q;
      resp_rdata_q   <= rd_pend_q ? fl_rdata : `FPG_ZERO_BYTE;
    end
  end
endmodule // flash_protection_gate
`default_nettype wire

//--- verif/flash_protection_gate_checker.sv
// assertion checker for the flash protection gate
`default_nettype none
`include "flash_protection_gate_regs.vh"
module flash_protection_gate_checker (
  input wire logic        clk_sys, rst_b, req_valid, req_rd, req_prog, req_erase, req_ready,
  input wire logic [15:0] req_addr, req_pc,
  input wire logic [7:0]  resp_rdata_q,
  input wire logic        resp_valid_q, resp_refused_q, fl_rd, fl_prog, fl_erase, fl_wipe,
  input wire logic        bsl_pw_match_q, data_flash_erase_unlock, protect_active, protect_mode,
  input wire logic        unlock_clear_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // own region decode, so a slip in the design's decode shows
  wire tk = req_valid & req_ready & (req_rd | req_prog | req_erase);
  wire pa = req_addr <= `FPG_PF_TOP;
  wire da = req_addr[15:12] == 4'h3;
  wire ra = req_addr >= `FPG_ROM_BASE && req_addr <= `FPG_ROM_TOP;
  wire fp = req_pc <= `FPG_PF_TOP || (protect_mode && req_pc[15:12] == 4'h3);
  wire st = fl_rd | fl_prog | fl_erase;
  wire pr = protect_active;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_rom_read_shut: assert property (tk && req_rd && ra |=> !fl_rd ##1 resp_refused_q)
    else $error("rom read passed");
  a_pf_write_shut: assert property (tk && !req_rd && pa && pr |=> !st ##1 resp_refused_q)
    else $error("pf write passed");
  a_pf_read_gate: assert property (tk && req_rd && pa && pr && !fp |=> !fl_rd ##1 resp_refused_q)
    else $error("pf read passed");
  a_df_mode_one: assert property (tk && da && pr && protect_mode && !(req_rd && fp) |=> !st)
    else $error("df access passed");
  a_df_mode_zero: assert property (tk && da && pr && !protect_mode && (req_rd || req_prog) |=> st)
    else $error("df access shut");
  a_df_erase_lock: assert property (tk && req_erase && !req_rd && !req_prog && da && pr && !protect_mode
    && !data_flash_erase_unlock |=> !fl_erase) else $error("df erase passed");
  a_unlock_pulse: assert property (tk && req_erase && !req_rd && da |=> unlock_clear_q)
    else $error("unlock not cleared");
  a_refused_empty: assert property (resp_refused_q |-> resp_valid_q && resp_rdata_q == 8'h00)
    else $error("refusal leaks");
  a_match_wipes: assert property (bsl_pw_match_q |-> fl_wipe && !req_ready)
    else $error("no wipe");
  a_guard_held: assert property (pr |=> pr)
    else $error("guard dropped");
  // main scenarios reached
  cover property (bsl_pw_match_q);
  cover property (tk && protect_mode);
  cover property (resp_refused_q);
endmodule // flash_protection_gate_checker
bind flash_protection_gate flash_protection_gate_checker i_chk (.*);
`default_nettype wire

//--- verif/flash_array_model.sv
// behavioural flash array facing the protection gate
`default_nettype none
module flash_array_model (
  input wire logic        clk_sys, fl_rd, fl_prog, fl_erase, fl_wipe,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0]  fl_wdata,
  output logic     [7:0]  fl_rdata,
  output logic            fl_wipe_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:16'hffff];
  logic [7:0] junk_q = 8'h5a;
  int         wc_q = 0;
  initial begin
    fl_wipe_done = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // noise outside the strobe so a stale byte never looks valid
  assign fl_rdata = fl_rd ? mem[fl_addr] : junk_q;
  // wipe only clears program flash: enough for mode 0 unprotect
  always @(posedge clk_sys) begin
    junk_q <= ~junk_q + 8'h01;
    fl_wipe_done <= 1'b0;
    wc_q <= fl_wipe ? wc_q + 1 : 0;
    if (fl_prog) mem[fl_addr] <= fl_wdata;
    if (fl_erase) mem[fl_addr] <= 8'h00;
    if (wc_q == 3) begin
      for (int i = 0; i <= 16'h2fff; i++) mem[i] <= 8'h00;
      fl_wipe_done <= 1'b1;
    end
  end
endmodule // flash_array_model
`default_nettype wire

//--- verif/flash_protection_gate_test.sv
// self-checking bench for the flash protection gate
`default_nettype none
`include "flash_protection_gate_regs.vh"
module flash_protection_gate_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = '0, rst_b = '0, req_valid = '0, req_rd = '0, req_prog = '0, req_erase = '0;
  logic        bsl_pw_prog = '0, bsl_pw_check = '0, data_flash_erase_unlock = '0;
  logic [15:0] req_addr = '0, req_pc = '0, bsl_pw_data = '0, fl_addr;
  logic [7:0]  req_wdata = '0, fl_wdata, fl_rdata, resp_rdata_q, ref_m [int];
  logic        req_ready, resp_valid_q, resp_refused_q, unlock_clear_q, bsl_pw_match_q, bsl_pw_done_q;
  logic        fl_rd, fl_prog, fl_erase, fl_wipe, fl_wipe_done, protect_active, protect_mode;
  int          n_fail = 0, cmp_count = 0, seed = 32'hedad;
  bit          act = 0, mode = 0, unl = 0;
  always #5 clk_sys = ~clk_sys;
  flash_protection_gate i_dut (.*);
  flash_array_model i_fl (.*);
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // reference decision for one access
  function automatic bit ok(bit rd, er, logic [15:0] a, pc);
    bit fp = pc <= `FPG_PF_TOP || (mode && pc[15:12] == 4'h3);
    if (rd && a >= `FPG_ROM_BASE && a <= `FPG_ROM_TOP) return 0;
    if (!act) return 1;
    if (a <= `FPG_PF_TOP) return rd && fp;
    if (a[15:12] == 4'h3) return mode ? rd && fp : rd || !er || unl;
    return 1;
  endfunction
  task automatic acc(int k, logic [15:0] a, pc);
    logic [7:0] wd = $random(seed);
    bit al;
    int n = 0;
    unl = $random(seed);
    al = ok(k == 0, k == 2, a, pc);
    @(posedge clk_sys);
    {req_valid, req_rd, req_prog, req_erase, req_addr, req_pc, req_wdata, data_flash_erase_unlock}
      <= {1'b1, k == 0, k == 1, k == 2, a, pc, wd, unl};
    @(posedge clk_sys);
    req_valid <= 1'b0;
    do @(negedge clk_sys); while (resp_valid_q !== 1'b1 && ++n < 6);
    if (resp_valid_q !== 1'b1) begin
      n_fail++;
      finish_test();
    end
    chk("refused", resp_refused_q, !al);
    chk("rdata", resp_rdata_q, al && k == 0 && ref_m.exists(a) ? ref_m[a] : 8'h00);
    if (al && k) ref_m[a] = k == 1 ? wd : 8'h00;
  endtask
  // random kinds, regions and issuing addresses
  task automatic run(int cnt);
    logic [15:0] b [4] = '{`FPG_PF_BASE, `FPG_DF_BASE, `FPG_ROM_BASE, 16'h4000};
    repeat (cnt) acc(($random(seed) & 3) % 3, b[$random(seed) & 3] | ($random(seed) & 15),
      b[$random(seed) & 3] | 16'h0040);
  endtask
  task automatic pw(bit c, logic [15:0] d, bit m);
    @(posedge clk_sys);
    {bsl_pw_prog, bsl_pw_check, bsl_pw_data} <= {!c, c, d};
    @(posedge clk_sys);
    {bsl_pw_prog, bsl_pw_check} <= 2'h0;
    @(negedge clk_sys);
    if (c) chk("match", bsl_pw_match_q, m);
    @(negedge clk_sys);
  endtask
  task automatic rst();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    act = 0;
    @(negedge clk_sys);
  endtask
  initial begin
    int n;
    rst();
    run(40);
    pw(0, 16'h2b6e, 0);
    act = 1;
    chk("mode", {protect_active, protect_mode}, 2'h2);
    run(60);
    $display("test mode0 done");
    pw(1, 16'h2b6f, 0);
    pw(1, 16'h2b6e, 1);
    for (n = 0; n < 50 && bsl_pw_done_q !== 1'b1; n++) @(negedge clk_sys);
    if (n == 50) begin
      n_fail++;
      finish_test();
    end
    chk("held", protect_active, 1);
    for (int i = 0; i < 16; i++) ref_m.delete(i);
    // a fresh password must not change the mode before reset
    pw(0, 16'hab6e, 0);
    chk("frozen", {protect_active, protect_mode}, 2'h2);
    run(10);
    rst();
    chk("cleared", {protect_active, protect_mode}, 2'h0);
    run(30);
    $display("test unprotect done");
    pw(0, 16'hab6e, 0);
    pw(0, 16'h2b6e, 0);
    act = 1;
    mode = 1;
    chk("mode", {protect_active, protect_mode}, 2'h3);
    run(60);
    $display("test mode1 done");
    finish_test();
  end
endmodule // flash_protection_gate_test
`default_nettype wire
